/* design/ccs_pkg.sv */
// package of constants and types for the compass register serial target
// Notes on behaviour
// - target only; never starts a bus transfer
// - answers address byte 0x88 write, 0x89 read
// - write then one byte loads the register pointer
// - read address acked, then pointed register is sent
// - master ack increments pointer, sends next register
// - single or block reads end with nack, stop
// - internal reset, watchdog supervises operation
// - calibration starts at power, repeats periodically
// - results are words, upper byte at even address
// - heading word is unsigned degrees times ten
// - other result words are two's complement
package ccs_pkg;
	// ************************************************************
	// bus addressing and register map
	// ************************************************************
	localparam logic [7:0] ADDR_WRITE = 8'h88;
	localparam logic [7:0] ADDR_READ  = 8'h89;
	localparam logic [7:0] REG_FIRST  = 8'h00;
	localparam logic [7:0] REG_LAST   = 8'h0D;
	localparam int         NUM_REGS   = 14;
	localparam int         NUM_WORDS  = 7;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	localparam logic [3:0] BITS_BYTE  = 4'h8;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0]  PTR_RST  = 8'h00;
	localparam logic [31:0] CNT_RST  = 32'h0000_0000;

	// ************************************************************
	// timing, each time in its own unit and its cycle count
	// ************************************************************
	localparam int CLK_HZ         = 100_000_000;
	localparam int WDOG_TIME_MS   = 10;
	localparam int WDOG_CYCLES    = WDOG_TIME_MS * (CLK_HZ / 1000);
	localparam int CAL_PERIOD_MS  = 1000;
	localparam int CAL_CYCLES     = CAL_PERIOD_MS * (CLK_HZ / 1000);

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_RDATA, ST_RACK, ST_IGNORE
	} ccs_state_t;

	typedef logic [NUM_REGS-1:0][7:0] ccs_bank_t;
endpackage

/* design/ccs_line_if.sv */
// interface carrying sampled bus lines and their events
`timescale 1ns/1ps
interface ccs_line_if;
	logic scl;       // synchronised clock line level
	logic sda;       // synchronised data line level
	logic scl_rise;  // clock line rose
	logic scl_fall;  // clock line fell
	logic start;     // start condition seen
	logic stop;      // stop condition seen
	modport sampler (output scl, sda, scl_rise, scl_fall, start, stop);
	modport core    (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface // ccs_line_if

/* design/ccs_line_sampler.sv */
// two-flop synchroniser and edge finder for the bus lines
`timescale 1ns/1ps
module ccs_line_sampler (
	input  wire logic  clk_sys,   // system clock
	input  wire logic  resetn,    // async reset, active low
	input  wire logic  scl_in,    // raw clock line
	input  wire logic  sda_in,    // raw data line
	ccs_line_if.sampler lines     // sampled lines and events
);
	typedef struct packed {
		logic [1:0] scl_sy;  // [0] first stage, [1] second stage
		logic [1:0] sda_sy;
		logic       scl_d;   // delayed second stage for edges
		logic       sda_d;
	} ccs_samp_t;

	ccs_samp_t s;
	ccs_samp_t next_s;

	// only the second stage feeds the edge logic, never the first
	always_comb begin
		next_s        = s;
		next_s.scl_sy = {s.scl_sy[0], scl_in};
		next_s.sda_sy = {s.sda_sy[0], sda_in};
		next_s.scl_d  = s.scl_sy[1];
		next_s.sda_d  = s.sda_sy[1];
	end

	// idle bus is high on both lines
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s <= '1;
		end else begin
			s <= next_s;
		end
	end

	assign lines.scl      = s.scl_sy[1];
	assign lines.sda      = s.sda_sy[1];
	assign lines.scl_rise = s.scl_sy[1] & ~s.scl_d;
	assign lines.scl_fall = ~s.scl_sy[1] & s.scl_d;
	// data edge while the clock stays high marks start or stop
	assign lines.start    = s.scl_sy[1] & s.scl_d & s.sda_d & ~s.sda_sy[1];
	assign lines.stop     = s.scl_sy[1] & s.scl_d & ~s.sda_d & s.sda_sy[1];
endmodule // ccs_line_sampler

/* design/ccs_target.sv */
// serial target port exposing the compass result registers
`timescale 1ns/1ps
module ccs_target #(
	parameter int unsigned WDOG_LIMIT = ccs_pkg::WDOG_CYCLES,  // stall timeout in cycles
	parameter int unsigned CAL_LIMIT  = ccs_pkg::CAL_CYCLES    // calibration period
) (
	input  wire logic                   clk_sys,        // system clock
	input  wire logic                   resetn,         // async power-on reset, low
	input  wire logic                   scl_in,         // clock line level
	output logic                        scl_out,        // clock line drive value
	output logic                        scl_oe,         // clock line drive enable
	input  wire logic                   sda_in,         // data line level
	output logic                        sda_out,        // data line drive value
	output logic                        sda_oe,         // data line drive enable
	input  wire logic [15:0]            heading_tenths, // unsigned heading x10
	input  wire logic [5:0][15:0]       attitude_words, // signed results, words 1..6
	input  wire logic                   result_load,    // strobe: new results ready
	output logic                        cal_start,      // pulse: begin calibration
	output logic [7:0]                  reg_pointer     // current register pointer
);
	import ccs_pkg::*;

	typedef struct packed {
		ccs_state_t  st;
		logic [3:0]  cnt;     // bits seen in current byte
		logic [7:0]  sh;      // receive or transmit shifter
		logic [7:0]  ptr;     // register pointer
		logic        rd;      // current frame is a read
		logic        acked;   // master acked last read byte
		logic        oe;      // pull data line low
		ccs_bank_t   bank;    // result registers
		logic        pend;    // results waiting for an idle bus
		logic [31:0] wdog;    // cycles without clock edge
		logic [31:0] cal;     // calibration period counter
		logic        cal_go;  // calibration start pulse
		logic        lvl;     // open-drain drive level, always low
	} ccs_core_t;

	ccs_core_t s;
	ccs_core_t next_s;
	ccs_line_if lines ();

	// ************************************************************
	// line sampling
	// ************************************************************
	ccs_line_sampler u_sampler (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.lines   (lines)
	);

	// unmapped pointers read a fixed value instead of wrapping into the bank
	function automatic logic [7:0] rd_byte(input ccs_bank_t b, input logic [7:0] p);
		if (p <= REG_LAST) begin
			rd_byte = b[p[3:0]];
		end else begin
			rd_byte = UNMAPPED_RD;
		end
	endfunction

	// ************************************************************
	// protocol engine, result capture, watchdog, calibration timer
	// ************************************************************
	always_comb begin
		next_s        = s;
		next_s.cal_go = 1'b0;
		next_s.lvl    = 1'b0;

		// results only land between frames so a block read never tears a word
		if (result_load) begin
			next_s.pend = 1'b1;
		end
		if ((s.pend || result_load) && s.st == ST_IDLE) begin
			next_s.pend = 1'b0;
			next_s.bank[0] = heading_tenths[15:8];
			next_s.bank[1] = heading_tenths[7:0];
			for (int w = 1; w < NUM_WORDS; w++) begin
				next_s.bank[2*w]   = attitude_words[w-1][15:8];
				next_s.bank[2*w+1] = attitude_words[w-1][7:0];
			end
		end

		// free-running calibration cadence, first pulse right after reset
		if (s.cal == 32'(CAL_LIMIT - 1)) begin
			next_s.cal = CNT_RST;
		end else begin
			next_s.cal = s.cal + 32'h1;
		end
		next_s.cal_go = (s.cal == CNT_RST);

		// watchdog counts quiet cycles inside a frame and restarts as it fires,
		// so the count never passes the limit while the frame is dropped
		if (s.st == ST_IDLE || lines.scl_rise || lines.scl_fall
		    || s.wdog >= 32'(WDOG_LIMIT - 1)) begin
			next_s.wdog = CNT_RST;
		end else begin
			next_s.wdog = s.wdog + 32'h1;
		end

		case (s.st)
			ST_ADDR: begin
				if (lines.scl_rise) begin
					next_s.sh  = {s.sh[6:0], lines.sda};
					next_s.cnt = s.cnt + 4'h1;
				end else if (lines.scl_fall && s.cnt == BITS_BYTE) begin
					if (s.sh == ADDR_WRITE || s.sh == ADDR_READ) begin
						next_s.oe = 1'b1;
						next_s.rd = s.sh[0];
						next_s.st = ST_ADDR_ACK;
					end else begin
						next_s.st = ST_IGNORE;
					end
				end
			end
			ST_ADDR_ACK: begin
				if (lines.scl_fall) begin
					next_s.cnt = 4'h0;
					if (s.rd) begin
						next_s.sh = rd_byte(s.bank, s.ptr);
						next_s.oe = ~next_s.sh[7];
						next_s.st = ST_RDATA;
					end else begin
						next_s.oe = 1'b0;
						next_s.st = ST_PTR;
					end
				end
			end
			ST_PTR: begin
				if (lines.scl_rise) begin
					next_s.sh  = {s.sh[6:0], lines.sda};
					next_s.cnt = s.cnt + 4'h1;
				end else if (lines.scl_fall && s.cnt == BITS_BYTE) begin
					next_s.ptr = s.sh;
					next_s.oe  = 1'b1;
					next_s.st  = ST_PTR_ACK;
				end
			end
			ST_PTR_ACK: begin
				// further write bytes are left unacknowledged
				if (lines.scl_fall) begin
					next_s.oe = 1'b0;
					next_s.st = ST_IGNORE;
				end
			end
			ST_RDATA: begin
				if (lines.scl_rise) begin
					next_s.cnt = s.cnt + 4'h1;
				end else if (lines.scl_fall) begin
					if (s.cnt == BITS_BYTE) begin
						next_s.oe = 1'b0;
						next_s.st = ST_RACK;
					end else begin
						next_s.sh = {s.sh[6:0], 1'b0};
						next_s.oe = ~s.sh[6];
					end
				end
			end
			ST_RACK: begin
				if (lines.scl_rise) begin
					next_s.acked = ~lines.sda;
					if (!lines.sda) begin
						next_s.ptr = s.ptr + 8'h1;
					end
				end else if (lines.scl_fall) begin
					next_s.cnt = 4'h0;
					if (s.acked) begin
						next_s.sh = rd_byte(s.bank, s.ptr);
						next_s.oe = ~next_s.sh[7];
						next_s.st = ST_RDATA;
					end else begin
						next_s.st = ST_IGNORE;
					end
				end
			end
			default: begin
			end
		endcase

		// start and stop override any state; the engine only listens
		if (lines.start) begin
			next_s.st  = ST_ADDR;
			next_s.cnt = 4'h0;
			next_s.oe  = 1'b0;
		end else if (lines.stop || s.wdog >= 32'(WDOG_LIMIT - 1)) begin
			next_s.st  = ST_IDLE;
			next_s.oe  = 1'b0;
		end
	end

	// internal reset clears pointer and counters; no clock drive ever
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s     <= '0;
			s.ptr <= PTR_RST;
			s.st  <= ST_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign sda_out     = s.lvl;
	assign sda_oe      = s.oe;
	assign scl_out     = s.lvl;
	assign scl_oe      = s.lvl;
	assign cal_start   = s.cal_go;
	assign reg_pointer = s.ptr;

	// ************************************************************
	// checks
	// ************************************************************
	a_clock_never_driven: assert property (
		@(posedge clk_sys) disable iff (!resetn) !scl_oe && !(s.st == ST_IDLE && sda_oe))
		else $error("target drove the bus outside a frame");

	a_address_ack: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(s.st == ST_ADDR && lines.scl_fall && s.cnt == BITS_BYTE && !lines.start && !lines.stop
		 && (s.sh == ADDR_WRITE || s.sh == ADDR_READ)) |=> (sda_oe && s.st == ST_ADDR_ACK))
		else $error("own address not acknowledged");

	a_foreign_address: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(s.st == ST_ADDR && lines.scl_fall && s.cnt == BITS_BYTE
		 && s.sh != ADDR_WRITE && s.sh != ADDR_READ) |=> !sda_oe [*2])
		else $error("foreign address acknowledged");

	a_pointer_write: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(s.st == ST_PTR && lines.scl_fall && s.cnt == BITS_BYTE && !lines.start && !lines.stop)
		|=> (reg_pointer == $past(s.sh) && sda_oe))
		else $error("pointer byte not loaded and acked");

	a_first_read_byte: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(s.st == ST_ADDR_ACK && s.rd && lines.scl_fall && !lines.start && !lines.stop)
		|=> (s.sh == rd_byte(s.bank, s.ptr) && sda_oe == ~s.sh[7]))
		else $error("first read byte not from pointed register");

	a_pointer_step: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(s.st == ST_RACK && lines.scl_rise && !lines.sda && !lines.start && !lines.stop)
		|=> reg_pointer == $past(reg_pointer) + 8'h1)
		else $error("pointer not advanced on master ack");

	a_stop_release: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		(lines.stop && !lines.start) |=> (!sda_oe && s.st == ST_IDLE))
		else $error("data line held after stop");

	a_watchdog_bound: assert property (
		@(posedge clk_sys) disable iff (!resetn) s.wdog < 32'(WDOG_LIMIT))
		else $error("stalled frame outlived the watchdog");

	a_cal_cadence: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		cal_start |-> (s.cal == 32'h1 || CAL_LIMIT == 1) ##1 !cal_start || CAL_LIMIT <= 2)
		else $error("calibration pulse out of cadence");

	a_heading_capture: assert property (
		@(posedge clk_sys) disable iff (!resetn)
		((s.pend || result_load) && s.st == ST_IDLE)
		|=> {s.bank[0], s.bank[1]} == $past(heading_tenths))
		else $error("heading word not stored upper byte first");
endmodule // ccs_target

/* tb/ccs_master_model.sv */
// bus master model that drives the two open-drain lines of the target
`timescale 1ns/1ps
module ccs_master_model (
	input  wire logic sda,     // resolved data line
	output logic      scl_drv, // clock line, 1 lets the pull-up win
	output logic      sda_drv  // data line, 1 lets the pull-up win
);
	// quarter of the 125 ns link period; the clock stands high between frames
	localparam realtime Q = 31.25;
	initial begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end
	// ************************************************************
	// line conditions and bit cells
	// ************************************************************
	// start or repeated start, data falls while the clock is high
	task automatic bus_start();
		sda_drv = 1'b1;
		#Q scl_drv = 1'b1;
		#Q sda_drv = 1'b0;
		#Q scl_drv = 1'b0;
	endtask
	// stop closes every frame, after which the target lets go of data
	task automatic bus_stop();
		#Q sda_drv = 1'b0;
		#Q scl_drv = 1'b1;
		#Q sda_drv = 1'b1;
		#Q;
	endtask
	// data changes only while the clock is low, read mid-high
	task automatic clk_bit(input logic b, output logic seen);
		#Q sda_drv = b;
		#Q scl_drv = 1'b1;
		#Q seen = sda;
		#Q scl_drv = 1'b0;
	endtask
	// byte out msb first, then the target's acknowledge
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
		clk_bit(1'b1, s);
		ack = ~s;
	endtask
	// byte in; the last byte of a read is left unacknowledged
	task automatic get_byte(input logic ack_it, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
		clk_bit(~ack_it, s);
	endtask
endmodule // ccs_master_model

/* tb/tb_top.sv */
// self-checking testbench for the compass register serial target
`timescale 1ns/1ps
module tb_top;
	import ccs_pkg::*;
	localparam int unsigned CAL_SIM  = 50;
	localparam int unsigned WDOG_SIM = 200;
	logic             clk_sys, resetn, scl, sda, scl_drv, sda_drv, ack;
	logic             scl_out, scl_oe, sda_out, sda_oe, result_load, cal_start;
	logic [15:0]      heading_tenths;
	logic [5:0][15:0] attitude_words;
	logic [7:0]       reg_pointer, p;
	int               errors, checks, cyc, rst_cyc, last_cal, seed;
	// wired-and lines with pull-ups; a party pulls low only when enabled and driving zero
	assign scl = scl_drv & ~(scl_oe & ~scl_out);
	assign sda = sda_drv & ~(sda_oe & ~sda_out);
	ccs_target #(.WDOG_LIMIT(WDOG_SIM), .CAL_LIMIT(CAL_SIM)) dut (
		.clk_sys(clk_sys), .resetn(resetn), .scl_in(scl), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.heading_tenths(heading_tenths), .attitude_words(attitude_words),
		.result_load(result_load), .cal_start(cal_start), .reg_pointer(reg_pointer));
	ccs_master_model mst (.sda(sda), .scl_drv(scl_drv), .sda_drv(sda_drv));
	// ************************************************************
	// checking and closing
	// ************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (errors == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// expected byte at a pointer: upper byte at even, unmapped reads zero
	function automatic logic [7:0] exp_byte(input logic [7:0] a);
		logic [15:0] w;
		if (a > REG_LAST) return UNMAPPED_RD;
		w = (a[3:1] == 3'h0) ? heading_tenths : attitude_words[a[3:1] - 3'h1];
		return a[0] ? w[7:0] : w[15:8];
	endfunction
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// timeout, clock line never driven, calibration cadence; sampled where outputs settled
	always @(negedge clk_sys) begin
		cyc++;
		if (cyc > 60000) begin
			errors++;
			$display("[ERR] %0t run did not complete", $time);
			finish_test();
		end
		if (resetn === 1'b1) begin
			check({scl_oe, scl_out}, 16'h0, "clock line driven");
			if (cal_start === 1'b1) begin
				if (last_cal > 0) check(16'(cyc - last_cal), 16'(CAL_SIM), "cal period");
				else check(16'(cyc - rst_cyc <= 3), 16'h1, "first cal late");
				last_cal = cyc;
			end
		end
	end
	// ************************************************************
	// stimulus tasks
	// ************************************************************
	// new results are taken only between frames, so load while idle
	task automatic load(input logic [15:0] h, input logic [5:0][15:0] a);
		@(negedge clk_sys);
		heading_tenths = h;
		attitude_words = a;
		result_load = 1'b1;
		@(negedge clk_sys);
		result_load = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic set_ptr(input logic [7:0] a);
		mst.bus_start();
		mst.put_byte(ADDR_WRITE, ack);
		check(ack, 16'h1, "write address ack");
		mst.put_byte(a, ack);
		check(ack, 16'h1, "pointer ack");
		mst.bus_stop();
		check(reg_pointer, a, "pointer load");
	endtask
	task automatic rd(input logic [7:0] a, input int n);
		logic [7:0] d;
		mst.bus_start();
		mst.put_byte(ADDR_READ, ack);
		check(ack, 16'h1, "read address ack");
		for (int i = 0; i < n; i++) begin
			mst.get_byte(i < n - 1, d);
			check(d, exp_byte(8'(a + i)), "read data");
		end
		mst.bus_stop();
		repeat (4) @(negedge clk_sys);
		check(sda_oe, 16'h0, "data line held");
		check(reg_pointer, 8'(a + n - 1), "pointer step");
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		seed = 32'h40e5;
		resetn = 1'b0;
		result_load = 1'b0;
		heading_tenths = 16'h0000;
		attitude_words = '0;
		repeat (5) @(negedge clk_sys);
		resetn = 1'b1;
		rst_cyc = cyc;
		repeat (4) @(negedge clk_sys);
		check(reg_pointer, PTR_RST, "pointer after reset");
		// extremes: 359.9 degrees, most negative and most positive words
		load(16'h0E0F, {16'h8000, 16'h7FFF, 16'hFFFF, 16'h0001, 16'h0000, 16'hA5C3});
		rd(8'h00, NUM_REGS);
		// a frame stalled with the data line held low is dropped by the watchdog
		mst.bus_start();
		mst.put_byte(ADDR_READ, ack);
		check(ack, 16'h1, "stall address ack");
		repeat (5) @(negedge clk_sys);
		check(sda_oe, 16'(exp_byte(REG_LAST) < 8'h80), "first bit driven");
		repeat (WDOG_SIM + 20) @(negedge clk_sys);
		check(sda_oe, 16'h0, "stalled frame released");
		mst.bus_stop();
		check(reg_pointer, REG_LAST, "pointer after stall");
		// foreign addresses stay unanswered
		for (int i = 0; i < 6; i++) begin
			mst.bus_start();
			mst.put_byte(8'h8A ^ 8'(i << 4), ack);
			check(ack, 16'h0, "foreign address ack");
			mst.bus_stop();
		end
		// pointer edges: last mapped, first unmapped, wrap past 0xFF
		set_ptr(REG_LAST);
		rd(REG_LAST, 2);
		set_ptr(8'hFF);
		rd(8'hFF, 2);
		for (int t = 0; t < 12; t++) begin
			load(16'({$random(seed)} % 3600), {$random(seed), $random(seed), $random(seed)});
			p = 8'({$random(seed)} % 16);
			set_ptr(p);
			rd(p, 1 + {$random(seed)} % 4);
		end
		finish_test();
	end
endmodule // tb_top
